//--- logic/rx_cfg_pkg.sv
// Package for the receiver output-configuration and rate-status registers
`default_nettype none
package rx_cfg_pkg;
    localparam logic [7:0] ADDR_OUTPUT_DATA_SETTING = 8'h02;
    localparam logic [7:0] ADDR_RATE_ERROR_STATUS = 8'h03;
    localparam logic [7:0] OUTPUT_DATA_SETTING_RESET = 8'h00;
    localparam int FORMAT_POS = 0;
    localparam int DEMOD_SEL_POS = 1;
    localparam int THROUGH_SEL_POS = 2;
    localparam int UNLOCK_MUTE_POS = 3;
    localparam int GPO_SEL_POS = 4;
    localparam int ERR_FUNC_POS = 6;
    localparam int NONPCM_MUTE_POS = 7;
    localparam int ERR_BIT_POS = 4;
    // Rate codes
    localparam logic [3:0] RATE_44K1 = 4'h0;
    localparam logic [3:0] RATE_OUT_OF_RANGE = 4'h1;
    localparam logic [3:0] RATE_48K = 4'h2;
    localparam logic [3:0] RATE_32K = 4'h3;
    localparam logic [3:0] RATE_88K2 = 4'h8;
    localparam logic [3:0] RATE_96K = 4'ha;
    localparam logic [3:0] RATE_64K = 4'hb;
    localparam logic [3:0] RATE_176K4 = 4'hc;
    localparam logic [3:0] RATE_128K = 4'hd;
    localparam logic [3:0] RATE_192K = 4'he;
    typedef enum logic [1:0] {
        GPO_CS_BIT1, GPO_THROUGH, GPO_LOW, GPO_HIGH
    } gpo_src_t;
    typedef struct packed {
        logic nonpcm_mute_enable;
        logic error_pin_function_select;
        gpo_src_t general_output_source_select;
        logic unlock_mute_enable;
        logic through_source_select;
        logic demod_input_select;
        logic audio_output_format;
    } out_cfg_t;
    typedef struct packed {
        logic pll_locked;
        logic parity_error;
        logic nonpcm;
        logic cs_bit1;
    } rx_state_t;
endpackage
`default_nettype wire

//--- logic/rx_cfg_status.sv
// Output-configuration and rate/error status registers of the receiver
`default_nettype none
module rx_cfg_status
    import rx_cfg_pkg::*;
(
    input wire logic i_sys_clk,
    input wire logic i_sys_rst,
    input wire logic i_wr_en,
    input wire logic i_rd_en,
    input wire logic [7:0] i_addr,
    input wire logic [7:0] i_wdata,
    output logic [7:0] o_rdata,
    input wire rx_state_t i_rx,
    input wire logic [3:0] i_rate_code,
    input wire logic i_audio_data,
    input wire logic i_primary_serial_input,
    input wire logic i_multipurpose_pin,
    output logic o_audio_data_output,
    output logic o_general_output,
    output logic o_error_pin,
    output out_cfg_t o_cfg
);
    ////////////////////////////////////////////////////////////////////
    // Register state
    out_cfg_t cfg;
    logic [7:0] rdata;

    // Synchroniser stages for the two S/PDIF pins of the through path
    logic prim_meta;
    logic prim_sync;
    logic mpin_meta;
    logic mpin_sync;

    ////////////////////////////////////////////////////////////////////
    // Address decode; only the two registers of this block answer
    wire hit_cfg = i_addr == ADDR_OUTPUT_DATA_SETTING;
    wire hit_stat = i_addr == ADDR_RATE_ERROR_STATUS;
    wire cfg_write = i_wr_en && hit_cfg;
    wire stat_read = i_rd_en && hit_stat;
    wire other_read = i_rd_en && !hit_cfg && !hit_stat;

    ////////////////////////////////////////////////////////////////////
    // Error condition: unlock or parity error; non-PCM is not an error
    wire data_error = !i_rx.pll_locked || i_rx.parity_error;

    // Mute sources, each when enabled: non-PCM stream, or lost lock
    wire nonpcm_mute = cfg.nonpcm_mute_enable && i_rx.nonpcm;
    wire unlock_mute = cfg.unlock_mute_enable && !i_rx.pll_locked;
    wire mute = nonpcm_mute || unlock_mute;

    // Error pin shows error flag or mute signal per function select
    wire next_err_pin = cfg.error_pin_function_select ? mute : data_error;

    // Through path picks a synchronised pin, never a raw one
    wire through_bit = cfg.through_source_select ? mpin_sync
                                                 : prim_sync;
    logic next_gpo;
    always_comb begin
        case (cfg.general_output_source_select)
            GPO_CS_BIT1: next_gpo = i_rx.cs_bit1;
            GPO_THROUGH: next_gpo = through_bit;
            GPO_LOW: next_gpo = 1'b0;
            default: next_gpo = 1'b1;
        endcase
    end
    // Status read: reserved bits zero, error bit mirrors error condition
    wire [7:0] stat_word = {3'h0, data_error, i_rate_code};
    wire [7:0] next_rdata = hit_cfg ? cfg : (hit_stat ? stat_word : 8'h00);
    ////////////////////////////////////////////////////////////////////
    // Pin inputs cross two flops before any logic reads them
    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            prim_meta <= 1'b0;
            prim_sync <= 1'b0;
            mpin_meta <= 1'b0;
            mpin_sync <= 1'b0;
        end else begin
            prim_meta <= i_primary_serial_input;
            prim_sync <= prim_meta;
            mpin_meta <= i_multipurpose_pin;
            mpin_sync <= mpin_meta;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Configuration register write; other addresses are ignored
    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst)
            cfg <= out_cfg_t'(OUTPUT_DATA_SETTING_RESET);
        else if (cfg_write)
            cfg <= out_cfg_t'(i_wdata);
    end
    // Registered outputs; muted data forced low
    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            o_audio_data_output <= 1'b0;
            o_general_output <= 1'b0;
            o_error_pin <= 1'b1;
            rdata <= 8'h00;
        end else begin
            o_audio_data_output <= mute ? 1'b0 : i_audio_data;
            o_general_output <= next_gpo;
            o_error_pin <= next_err_pin;
            if (i_rd_en)
                rdata <= next_rdata;
        end
    end
    assign o_rdata = rdata;
    assign o_cfg = cfg;
    ////////////////////////////////////////////////////////////////////
    a_nonpcm_mute: assert property (@(posedge i_sys_clk) disable iff
        (i_sys_rst) nonpcm_mute |=> !o_audio_data_output)
        else $error("data not muted on non-PCM");
    a_nonpcm_no_err: assert property (@(posedge i_sys_clk) disable iff
        (i_sys_rst) (!cfg.error_pin_function_select && i_rx.pll_locked &&
        !i_rx.parity_error && i_rx.nonpcm) |=> !o_error_pin)
        else $error("non-PCM flagged as error");
    a_rate_read: assert property (@(posedge i_sys_clk) disable iff
        (i_sys_rst) (i_rd_en && hit_stat) |=>
        o_rdata[3:0] == $past(i_rate_code))
        else $error("rate code mismatch");
    a_err_mirror: assert property (@(posedge i_sys_clk) disable iff
        (i_sys_rst) (i_rd_en && hit_stat && cfg.error_pin_function_select
        == 1'b0) |=> o_rdata[ERR_BIT_POS] == o_error_pin)
        else $error("error bit differs from pin");
    a_err_value: assert property (@(posedge i_sys_clk) disable iff
        (i_sys_rst) (i_rd_en && hit_stat) |=> o_rdata[ERR_BIT_POS] ==
        $past(!i_rx.pll_locked || i_rx.parity_error))
        else $error("error bit wrong");
    a_reserved_zero: assert property (@(posedge i_sys_clk) disable iff
        (i_sys_rst) (i_rd_en && hit_stat) |=> o_rdata[7:5] == 3'h0)
        else $error("reserved bits not zero");
    a_reset_clear: assert property (@(posedge i_sys_clk)
        i_sys_rst |=> cfg == '0)
        else $error("config not cleared");
    a_cfg_write: assert property (@(posedge i_sys_clk) disable iff
        (i_sys_rst) (i_wr_en && hit_cfg) |=> o_cfg == $past(i_wdata))
        else $error("config write lost");

    ////////////////////////////////////////////////////////////////////
    // Configuration only changes on a write to its own address
    a_cfg_hold: assert property (@(posedge i_sys_clk) disable iff
        (i_sys_rst) !cfg_write |=> $stable(o_cfg))
        else $error("config changed without write");

    // Read data stands until the next read strobe
    a_rdata_hold: assert property (@(posedge i_sys_clk) disable iff
        (i_sys_rst) !i_rd_en |=> $stable(o_rdata))
        else $error("read data changed without read");

    // Reads of addresses outside the block return zero
    a_other_zero: assert property (@(posedge i_sys_clk) disable iff
        (i_sys_rst) other_read |=> o_rdata == 8'h00)
        else $error("unmapped read not zero");

    // Unlock muting forces the data output low
    a_unlock_mute: assert property (@(posedge i_sys_clk) disable iff
        (i_sys_rst) unlock_mute |=> !o_audio_data_output)
        else $error("data not muted on unlock");

    // Without any mute the data output follows the demodulator
    a_data_pass: assert property (@(posedge i_sys_clk) disable iff
        (i_sys_rst) !mute |=> o_audio_data_output == $past(i_audio_data))
        else $error("data not passed through");

    // Error function on the pin follows unlock or parity error
    a_err_func: assert property (@(posedge i_sys_clk) disable iff
        (i_sys_rst) !cfg.error_pin_function_select |=>
        o_error_pin == $past(data_error))
        else $error("error pin wrong in error mode");

    // Mute function on the pin follows the mute signal
    a_mute_pin: assert property (@(posedge i_sys_clk) disable iff
        (i_sys_rst) cfg.error_pin_function_select |=>
        o_error_pin == $past(mute))
        else $error("error pin wrong in mute mode");

    // Fixed levels on the general output
    a_gpo_fixed: assert property (@(posedge i_sys_clk) disable iff
        (i_sys_rst) (cfg.general_output_source_select == GPO_LOW ||
        cfg.general_output_source_select == GPO_HIGH) |=>
        o_general_output == $past(cfg.general_output_source_select ==
        GPO_HIGH))
        else $error("general output level wrong");

    // Channel-status bit on the general output
    a_gpo_cs: assert property (@(posedge i_sys_clk) disable iff
        (i_sys_rst) cfg.general_output_source_select == GPO_CS_BIT1 |=>
        o_general_output == $past(i_rx.cs_bit1))
        else $error("general output not status bit");

    // Outputs take their reset levels during reset
    a_reset_outs: assert property (@(posedge i_sys_clk)
        i_sys_rst |=> o_error_pin && !o_audio_data_output &&
        !o_general_output && o_rdata == 8'h00)
        else $error("outputs not at reset levels");

    ////////////////////////////////////////////////////////////////////
    // Main scenarios
    c_nonpcm: cover property (@(posedge i_sys_clk) nonpcm_mute);
    c_unlock: cover property (@(posedge i_sys_clk) unlock_mute);
    c_status_rd: cover property (@(posedge i_sys_clk) i_rd_en && hit_stat);
    c_mute_pin: cover property (@(posedge i_sys_clk)
        cfg.error_pin_function_select && mute);
    c_through: cover property (@(posedge i_sys_clk)
        cfg.general_output_source_select == GPO_THROUGH && through_bit);
endmodule
`default_nettype wire

//--- sim/tb.sv
// Self-checking testbench for the configuration and rate/error registers
`default_nettype none
module tb import rx_cfg_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic i_sys_clk = 1'b0, i_sys_rst = 1'b1, wr = 1'b0, rd = 1'b0, ad = 1'b0;
    logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, v;
    logic [3:0] rate = 4'h0;
    logic prim = 1'b0, mpin = 1'b0;
    logic ado, general_output, errp;
    rx_state_t rx = 4'h8;
    out_cfg_t cfg;
    int fail_count = 0, check_count = 0;
    logic [3:0] codes [10] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h8, 4'ha, 4'hb,
        4'hc, 4'hd, 4'he};
    // Clock and device under test
    always #5 i_sys_clk = ~i_sys_clk;
    rx_cfg_status u_dut (.i_sys_clk(i_sys_clk), .i_sys_rst(i_sys_rst),
        .i_wr_en(wr), .i_rd_en(rd), .i_addr(addr), .i_wdata(wdata),
        .o_rdata(rdata), .i_rx(rx), .i_rate_code(rate), .i_audio_data(ad),
        .i_primary_serial_input(prim), .i_multipurpose_pin(mpin),
        .o_audio_data_output(ado), .o_general_output(general_output),
        .o_error_pin(errp), .o_cfg(cfg));
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
        check_count++;
        if (s !== e) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, s);
        end
    endtask
    // One-cycle strobe, then settle
    task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge i_sys_clk) #1;
        {wr, rd, addr, wdata} = {w, ~w, a, d};
        @(posedge i_sys_clk) #1;
        {wr, rd} = 2'b00;
        @(posedge i_sys_clk) #1;
    endtask
    task automatic test_regs();
        acc(0, 8'h02, 8'h00);
        chk("cfg reset", rdata, 8'h00);
        acc(1, 8'h02, 8'hff);
        acc(1, 8'h05, 8'h00);
        acc(0, 8'h02, 8'h00);
        chk("cfg rw", rdata, 8'hff);
        acc(0, 8'h05, 8'h00);
        chk("unmapped", rdata, 8'h00);
        $display("test_regs done");
    endtask
    task automatic test_rate();
        acc(1, 8'h02, 8'h00);
        foreach (codes[i]) begin
            rate = codes[i];
            rx = (i % 2) ? 4'hc : 4'h8;
            acc(0, 8'h03, 8'h00);
            chk("status", rdata, {3'h0, i % 2 == 1, codes[i]});
            chk("err pin", {7'h0, errp}, {7'h0, i % 2 == 1});
        end
        rx = 4'h0;
        acc(0, 8'h03, 8'h00);
        chk("unlock err", rdata, {4'h1, codes[9]});
        $display("test_rate done");
    endtask
    task automatic test_mute();
        {rx, ad} = {4'ha, 1'b1};
        acc(1, 8'h80, 8'h00);
        acc(1, 8'h02, 8'h80);
        chk("mute out", {7'h0, ado}, 8'h00);
        chk("mute err", {7'h0, errp}, 8'h00);
        rx = 4'h8;
        acc(0, 8'h03, 8'h00);
        chk("pcm out", {7'h0, ado}, 8'h01);
        $display("test_mute done");
    endtask
    // Unlock muting, mute function on the pin, general output sources
    task automatic test_gpo_err();
        {rx, ad, rate} = {4'h0, 1'b1, 4'h3};
        acc(1, 8'h02, 8'h48);
        chk("unlock mute", {7'h0, ado}, 8'h00);
        chk("mute pin", {7'h0, errp}, 8'h01);
        acc(0, 8'h03, 8'h00);
        chk("err flag", rdata, 8'h13);
        rx = 4'h8;
        acc(0, 8'h03, 8'h00);
        chk("unmuted pin", {7'h0, errp}, 8'h00);
        chk("unmuted out", {7'h0, ado}, 8'h01);
        rx = 4'h9;
        acc(1, 8'h02, 8'h00);
        chk("cfg cleared", cfg, 8'h00);
        chk("gpo cs bit", {7'h0, general_output}, 8'h01);
        acc(1, 8'h02, 8'h20);
        chk("gpo low", {7'h0, general_output}, 8'h00);
        acc(1, 8'h02, 8'h30);
        chk("gpo high", {7'h0, general_output}, 8'h01);
        prim = 1'b1;
        acc(1, 8'h02, 8'h10);
        chk("gpo primary", {7'h0, general_output}, 8'h01);
        mpin = 1'b0; // pin driven as an input, so it may be chosen
        acc(1, 8'h02, 8'h14);
        chk("gpo multipurpose", {7'h0, general_output}, 8'h00);
        $display("test_gpo_err done");
    endtask
    // Reset in mid-run clears the configuration
    task automatic test_reset();
        acc(1, 8'h02, 8'hff);
        chk("cfg written", cfg, 8'hff);
        i_sys_rst = 1'b1;
        @(posedge i_sys_clk) #1;
        @(posedge i_sys_clk) #1;
        chk("reset err pin", {7'h0, errp}, 8'h01);
        chk("reset data out", {7'h0, ado}, 8'h00);
        i_sys_rst = 1'b0;
        chk("cfg after reset", cfg, 8'h00);
        acc(0, 8'h02, 8'h00);
        chk("cfg read after reset", rdata, 8'h00);
        $display("test_reset done");
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        repeat (2) @(posedge i_sys_clk);
        #1 i_sys_rst = 1'b0;
        test_regs();
        test_rate();
        test_mute();
        test_gpo_err();
        test_reset();
        finish_test();
    end
    initial begin
        #20000;
        fail_count++;
        finish_test();
    end
endmodule
`default_nettype wire
